// [rtl/dsi_interlock.v]
// Drive start interlock: restart permission, local/mixed chord, power-on
// start delay and reversal zeroing, with an AXI4-Lite register slave.
// Assumes all inputs are synchronous to sys_clk_i and the bus is AXI4-Lite.
//
// Local design decisions: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "dsi_consts.vh"
module dsi_interlock #(
  parameter TICK_CYC = `DSI_TICK_CYC         // Clock cycles per 0.1 ms tick.
) (
  // Clock and reset.
  input  wire        sys_clk_i,
  input  wire        rst_i,
  // Drive status and terminal inputs.
  input  wire        alarm_i,
  input  wire        power_ok_i,
  input  wire        enable_i,
  input  wire        start_i,
  input  wire        dir_req_i,
  // Keypad inputs.
  input  wire        key_up_i,
  input  wire        key_save_i,
  input  wire        key_start_i,
  // Drive outputs.
  output reg         run_o,
  output reg         bridge_fwd_o,
  output reg         bridge_rev_o,
  output reg         local_mode_o,
  output reg  [7:0]  warning_code_o,
  output reg         irq_o,
  // AXI4-Lite write address channel.
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // AXI4-Lite write data channel.
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // AXI4-Lite write response channel.
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address channel.
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // AXI4-Lite read data channel.
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  localparam [1:0] IL_FREE    = 2'h0;        // Start evaluation is normal.
  localparam [1:0] IL_WAIT_HI = 2'h1;        // Waiting for enable to close.
  localparam [1:0] IL_WAIT_LO = 2'h2;        // Waiting for enable to open.
  localparam [1:0] RESP_OKAY  = 2'h0;        // Normal bus answer.
  localparam [1:0] RESP_SLV   = 2'h2;        // Unmapped address answer.

  reg  [3:0]  ctrl_r;                        // Configuration bits.
  reg  [16:0] pwron_r;                       // Power-on delay, ticks.
  reg  [16:0] zero_r;                        // Zeroing interval, ticks.
  reg  [3:0]  int_stat_r;                    // Sticky event bits.
  reg  [3:0]  int_mask_r;                    // Event enables.
  reg  [1:0]  il_state_r;                    // Interlock state.
  reg  [1:0]  il_state_nxt;                  // Interlock next state.
  reg         alarm_d_r;                     // Alarm, one cycle late.
  reg         power_d_r;                     // Supply ok, one cycle late.
  reg         enable_d_r;                    // Enable, one cycle late.
  reg         chord_d_r;                     // Key chord, one cycle late.
  reg         dir_r;                         // Direction now applied.
  reg         pwron_load_r;                  // Starts the power-on timer.
  reg         pwron_done_r;                  // Power-on delay has run.
  reg  [15:0] div_r;                         // Tick divider count.
  reg         tick_r;                        // 0.1 ms enable pulse.
  reg         aw_got_r;                      // Write address held.
  reg         w_got_r;                       // Write data held.
  reg  [7:0]  aw_addr_r;                     // Held write address.
  reg  [31:0] w_data_r;                      // Held write data.
  reg  [3:0]  w_strb_r;                      // Held byte strobes.
  reg  [3:0]  ev;                            // Events of this cycle.
  reg  [3:0]  w1c;                           // Bits cleared by software.
  reg  [16:0] wr_val;                        // Clamped timing value.
  wire        pwron_busy;                    // Power-on timer running.
  wire        pwron_fire;                    // Power-on timer expired.
  wire        zero_busy;                     // Zeroing timer running.
  wire        zero_fire;                     // Zeroing timer expired.
  wire        inductive;                     // Inductive load selected.
  wire        restart_ok;                    // Restart is possible now.
  wire        start_cmd;                     // Start from an allowed source.
  wire        arm_evt;                       // Alarm cleared or supply back.
  wire        chord;                         // Up and save held together.
  wire        run_nxt;                       // Run permission.
  wire        rev_start;                     // Reversal must zero first.
  wire        wr_fire;                       // Write address and data held.
  wire        waiting;                       // Interlock awaits a toggle.

  assign inductive = ctrl_r[`DSI_CTRL_INDUCTIVE];
  assign start_cmd = local_mode_o ? key_start_i
                   : (start_i | key_start_i | ctrl_r[`DSI_CTRL_SW_START]);
  assign restart_ok = ~alarm_i & power_ok_i & enable_i & start_cmd;
  assign arm_evt    = (alarm_d_r & ~alarm_i) | (~power_d_r & power_ok_i);
  assign chord      = key_up_i & key_save_i;
  assign waiting    = il_state_r != IL_FREE;
  // enable required
  // The power-on gate only holds back an inductive load.
  assign run_nxt    = restart_ok & ~waiting & (pwron_done_r | ~inductive);
  // The done pulse must not start a second zeroing for the same reversal.
  assign rev_start  = inductive & run_o & (dir_req_i != dir_r) & ~zero_busy & ~zero_fire;
  assign wr_fire    = aw_got_r & w_got_r & ~s_axi_bvalid;

  ////////////////////////////////////////////////////////////////////////////
  // Tick divider and timers.

  // One-cycle tick every TICK_CYC clocks paces both timers.
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_r  <= 16'h0000;
      tick_r <= 1'b0;
    end else if (div_r == TICK_CYC[15:0] - 16'h0001) begin
      div_r  <= 16'h0000;
      tick_r <= 1'b1;
    end else begin
      div_r  <= div_r + 16'h0001;
      tick_r <= 1'b0;
    end
  end

  // Power-on delay timer, loaded after control power comes up and again by a delay write before it expires.
  dsi_timer #(.W(17)) u_pwron (
    .sys_clk_i  (sys_clk_i),
    .rst_i      (rst_i),
    .tick_i     (tick_r),
    .load_i     (pwron_load_r),
    .load_val_i (pwron_r),
    .busy_o     (pwron_busy),
    .done_o     (pwron_fire)
  );

  // Zeroing timer, loaded when a running inductive drive reverses.
  dsi_timer #(.W(17)) u_zero (
    .sys_clk_i  (sys_clk_i),
    .rst_i      (rst_i),
    .tick_i     (tick_r),
    .load_i     (rev_start),
    .load_val_i (zero_r),
    .busy_o     (zero_busy),
    .done_o     (zero_fire)
  );

  // Gates the first start of an inductive load until the power-on delay has elapsed.
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pwron_load_r <= 1'b1;
      pwron_done_r <= 1'b0;
    end else begin
      // A delay written while the first one still runs restarts it.
      pwron_load_r <= wr_fire && !pwron_done_r && (&w_strb_r[2:0]) &&
                      ({aw_addr_r[7:2], 2'b00} == `DSI_OFS_PWRON);
      if (pwron_fire)
        pwron_done_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Restart interlock.

  // Next interlock state from arming events and enable edges.
  always @* begin
    il_state_nxt = il_state_r;
    case (il_state_r)
      IL_FREE: begin
        if (ctrl_r[`DSI_CTRL_INTERLOCK] && arm_evt)
          il_state_nxt = enable_i ? IL_WAIT_LO : IL_WAIT_HI;
      end
      IL_WAIT_HI: begin
        if (enable_i && !enable_d_r)
          il_state_nxt = IL_WAIT_LO;
      end
      IL_WAIT_LO: begin
        if (!enable_i && enable_d_r && enable_d_r)
          il_state_nxt = IL_FREE;
      end
      default: il_state_nxt = IL_FREE;
    endcase
  end

  // Registers interlock state and input history.
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      il_state_r <= IL_FREE;
      alarm_d_r  <= 1'b0;
      power_d_r  <= 1'b0;
      enable_d_r <= 1'b0;
      chord_d_r  <= 1'b0;
    end else begin
      il_state_r <= il_state_nxt;
      alarm_d_r  <= alarm_i;
      power_d_r  <= power_ok_i;
      enable_d_r <= enable_i;
      chord_d_r  <= chord;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Drive outputs.

  // Run, bridge, mode and warning outputs.
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      run_o          <= 1'b0;
      dir_r          <= 1'b0;
      bridge_fwd_o   <= 1'b0;
      bridge_rev_o   <= 1'b0;
      local_mode_o   <= 1'b0;
      warning_code_o <= `DSI_WARN_NONE;
    end else begin
      run_o <= run_nxt;
      if (!inductive || !run_o || zero_fire)
        dir_r <= dir_req_i;
      // Bridges stay off on the done pulse, while the new direction loads.
      bridge_fwd_o <= run_nxt & ~zero_busy & ~zero_fire & ~rev_start & ~dir_r;
      bridge_rev_o <= run_nxt & ~zero_busy & ~zero_fire & ~rev_start & dir_r;
      if (chord && !chord_d_r && !ctrl_r[`DSI_CTRL_LOCK])
        local_mode_o <= ~local_mode_o;
      if (waiting && ~alarm_i && power_ok_i)
        warning_code_o <= `DSI_WARN_ENABLE;
      else
        warning_code_o <= `DSI_WARN_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bus slave.

  // Events and write-one-to-clear bits of this cycle.
  always @* begin
    ev = 4'h0;
    ev[`DSI_EV_WARN]       = il_state_r == IL_FREE && il_state_nxt != IL_FREE;
    ev[`DSI_EV_MODE]       = chord & ~chord_d_r & ~ctrl_r[`DSI_CTRL_LOCK];
    ev[`DSI_EV_ZERO_DONE]  = zero_fire;
    ev[`DSI_EV_PWRON_DONE] = pwron_fire;
    w1c = 4'h0;
    if (wr_fire && aw_addr_r == `DSI_OFS_INT_STAT && w_strb_r[0])
      w1c = w_data_r[3:0];
    wr_val = w_data_r[16:0];
    if (aw_addr_r == `DSI_OFS_PWRON) begin
      if (wr_val > `DSI_PWRON_MAX)
        wr_val = `DSI_PWRON_MAX;
    end else if (wr_val < `DSI_ZERO_MIN) begin
      wr_val = `DSI_ZERO_MIN;
    end else if (wr_val > `DSI_ZERO_MAX) begin
      wr_val = `DSI_ZERO_MAX;
    end
  end

  // Write channels are taken in either order; the answer follows both.
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_data_r      <= 32'h00000000;
      w_strb_r      <= 4'h0;
      ctrl_r        <= `DSI_CTRL_RST;
      pwron_r       <= `DSI_PWRON_RST;
      zero_r        <= `DSI_ZERO_RST;
      int_mask_r    <= 4'h0;
      int_stat_r    <= 4'h0;
      irq_o         <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r      <= 1'b1;
        aw_addr_r     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r      <= 1'b1;
        w_data_r     <= s_axi_wdata;
        w_strb_r     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= RESP_OKAY;
        case ({aw_addr_r[7:2], 2'b00})
          `DSI_OFS_CTRL: begin
            if (w_strb_r[0])
              ctrl_r <= w_data_r[3:0];
          end
          `DSI_OFS_PWRON: begin
            if (&w_strb_r[2:0])
              pwron_r <= wr_val;
          end
          `DSI_OFS_ZERO: begin
            if (&w_strb_r[2:0])
              zero_r <= wr_val;
          end
          `DSI_OFS_INT_MASK: begin
            if (w_strb_r[0])
              int_mask_r <= w_data_r[3:0];
          end
          `DSI_OFS_STATUS, `DSI_OFS_INT_STAT: s_axi_bresp <= RESP_OKAY;
          default: s_axi_bresp <= RESP_SLV;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_got_r      <= 1'b0;
        w_got_r       <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      // A hardware event wins over a clear in the same cycle.
      int_stat_r <= (int_stat_r & ~w1c) | ev;
      irq_o      <= |(((int_stat_r & ~w1c) | ev) & int_mask_r);
    end
  end

  // Read channel: address taken, data answered one cycle later.
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= RESP_OKAY;
        s_axi_rdata   <= 32'h00000000;
        case ({s_axi_araddr[7:2], 2'b00})
          `DSI_OFS_CTRL:     s_axi_rdata[3:0]  <= ctrl_r;
          `DSI_OFS_PWRON:    s_axi_rdata[16:0] <= pwron_r;
          `DSI_OFS_ZERO:     s_axi_rdata[16:0] <= zero_r;
          `DSI_OFS_STATUS: begin
            s_axi_rdata[`DSI_ST_RUN]        <= run_o;
            s_axi_rdata[`DSI_ST_WARN]       <= waiting;
            s_axi_rdata[`DSI_ST_LOCAL]      <= local_mode_o;
            s_axi_rdata[`DSI_ST_PWRON_DONE] <= pwron_done_r;
            s_axi_rdata[`DSI_ST_ZEROING]    <= zero_busy;
            s_axi_rdata[`DSI_ST_DIR]        <= dir_r;
            s_axi_rdata[15:8]               <= warning_code_o;
          end
          `DSI_OFS_INT_STAT: s_axi_rdata[3:0]  <= int_stat_r;
          `DSI_OFS_INT_MASK: s_axi_rdata[3:0]  <= int_mask_r;
          default:           s_axi_rresp       <= RESP_SLV;
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // dsi_interlock

// [rtl/dsi_consts.vh]
// Constants of the drive start interlock: register map, field positions,
// reset values and timing counts.
// Assumes a 200 MHz system clock and a 32-bit AXI4-Lite register bus.
`ifndef DSI_CONSTS_VH
`define DSI_CONSTS_VH

// Register byte offsets.
`define DSI_OFS_CTRL        8'h00
`define DSI_OFS_PWRON       8'h04
`define DSI_OFS_ZERO        8'h08
`define DSI_OFS_STATUS      8'h0C
`define DSI_OFS_INT_STAT    8'h10
`define DSI_OFS_INT_MASK    8'h14

// Control register fields.
`define DSI_CTRL_INTERLOCK  0
`define DSI_CTRL_LOCK       1
`define DSI_CTRL_INDUCTIVE  2
`define DSI_CTRL_SW_START   3
`define DSI_CTRL_RST        4'h0

// Status register fields.
`define DSI_ST_RUN          0
`define DSI_ST_WARN         1
`define DSI_ST_LOCAL        2
`define DSI_ST_PWRON_DONE   3
`define DSI_ST_ZEROING      4
`define DSI_ST_DIR          5

// Interrupt event bits.
`define DSI_EV_WARN         0
`define DSI_EV_MODE         1
`define DSI_EV_ZERO_DONE    2
`define DSI_EV_PWRON_DONE   3
`define DSI_EV_W            4

// Warning code shown while the interlock waits for an enable toggle.
`define DSI_WARN_NONE       8'h00
`define DSI_WARN_ENABLE     8'h04

// Timing: one tick is 0.1 ms; counts are in ticks.
`define DSI_CLK_PERIOD_PS   5000
`define DSI_TICK_PS         100000000
`define DSI_TICK_CYC        (`DSI_TICK_PS / `DSI_CLK_PERIOD_PS)
`define DSI_PWRON_MAX       17'h186A0
`define DSI_PWRON_RST       17'h186A0
`define DSI_ZERO_MIN        17'h0012C
`define DSI_ZERO_MAX        17'h07530
`define DSI_ZERO_RST        17'h007D0

`endif

// [rtl/dsi_timer.v]
// Down-counting interval timer advanced by a shared tick enable.
// Assumes tick_i is a one-cycle pulse of the system clock domain.
`timescale 1ns/1ps
module dsi_timer #(
  parameter W = 17                           // Counter width.
) (
  // Clock and reset.
  input  wire         sys_clk_i,
  input  wire         rst_i,
  // Control.
  input  wire         tick_i,
  input  wire         load_i,
  input  wire [W-1:0] load_val_i,
  // Status.
  output reg          busy_o,
  output reg          done_o
);

  reg [W-1:0] cnt_r;                          // Ticks still to run.

  // A load restarts the interval; a zero load finishes on the next cycle.
  always @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r  <= {W{1'b0}};
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (load_i) begin
        cnt_r  <= load_val_i;
        busy_o <= 1'b1;
      end else if (busy_o) begin
        if (cnt_r == {W{1'b0}}) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end else if (tick_i) begin
          cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // dsi_timer

// [tb/dsi_interlock_properties.sv]
// Concurrent checks on the ports of the drive start interlock.
// Assumes one clock domain and an active-high asynchronous reset.
`timescale 1ns/1ps
module dsi_interlock_properties (
  // Clock and reset.
  input wire       sys_clk_i,
  input wire       rst_i,
  // Drive and keypad side.
  input wire       alarm_i,
  input wire       power_ok_i,
  input wire       enable_i,
  input wire       key_up_i,
  input wire       key_save_i,
  input wire       key_start_i,
  input wire       run_o,
  input wire       bridge_fwd_o,
  input wire       bridge_rev_o,
  input wire       local_mode_o,
  input wire [7:0] warning_code_o,
  // Register bus handshakes.
  input wire       s_axi_awready,
  input wire       s_axi_wready,
  input wire       s_axi_bvalid,
  input wire       s_axi_arvalid,
  input wire       s_axi_arready,
  input wire       s_axi_rvalid
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////
  run_enable_a:
    assert property (!enable_i |=> !run_o) else $error("run without enable");
  run_rise_a:
    assert property ($rose(run_o) |-> $past(enable_i && power_ok_i && !alarm_i))
    else $error("run rose without supply, enable or alarm clear");
  warn_clear_a:
    assert property ((alarm_i || !power_ok_i) |=> warning_code_o == 8'h00)
    else $error("warning shown while restart impossible");
  warn_run_a:
    assert property (warning_code_o == 8'h04 |-> !run_o) else $error("run while waiting");
  mode_chord_a:
    assert property ($changed(local_mode_o) |-> $past(key_up_i && key_save_i) &&
                     !$past(key_up_i && key_save_i, 2)) else $error("mode changed without chord");
  local_start_a:
    assert property (local_mode_o && !key_start_i |=> !run_o) else $error("local run without key");
  bridge_excl_a:
    assert property (!(bridge_fwd_o && bridge_rev_o)) else $error("both bridges on");
  rd_answer_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late read data");
  wr_busy_a:
    assert property ($rose(s_axi_bvalid) |-> !s_axi_awready && !s_axi_wready) else $error("ready in write");
  // Main scenarios reached.
  cover property ($rose(run_o));
  cover property ($rose(local_mode_o));
  cover property (warning_code_o == 8'h04);
endmodule // dsi_interlock_properties

// [tb/dsi_keypad_model.sv]
// Operator keypad: presses the up and save chord on request, save one
// cycle after up, and holds the start key as asked.
// Assumes chord requests are single-cycle pulses on the system clock.
`timescale 1ns/1ps
module dsi_keypad_model (
  // Clock and requests.
  input  wire logic sys_clk_i,
  input  wire logic chord_req_i,
  input  wire logic start_req_i,
  // Keys.
  output logic      key_up_o,
  output logic      key_save_o,
  output logic      key_start_o
);
  logic [3:0] hold_r = 4'h0;  // Cycles the chord is still held.
  always @(posedge sys_clk_i) begin
    if (chord_req_i) begin
      hold_r <= 4'hA;
    end else if (hold_r != 4'h0) begin
      hold_r <= hold_r - 4'h1;
    end
  end
  assign key_up_o    = hold_r != 4'h0;
  assign key_save_o  = hold_r != 4'h0 && hold_r != 4'hA;
  assign key_start_o = start_req_i;
endmodule // dsi_keypad_model

// [tb/tb_dsi_interlock.sv]
// Self-checking bench for the drive start interlock.
// Assumes a 200 MHz clock and a shortened 0.1 ms tick of TK cycles.
`timescale 1ns/1ps
module tb_dsi_interlock;
  localparam int TK = 4;  // Cycles per tick in simulation.
  logic        sys_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        alarm_i = 1'b0, power_ok_i = 1'b1, enable_i = 1'b1, start_i = 1'b1, dir_req_i = 1'b0;
  logic        chord_req = 1'b0, start_req = 1'b0;
  logic        key_up_i, key_save_i, key_start_i;
  logic        run_o, bridge_fwd_o, bridge_rev_o, local_mode_o, irq_o;
  logic [7:0]  warning_code_o;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  int          num_errors = 0;
  int          n_tests = 0;
  int          n;
  always #2.5 sys_clk_i = ~sys_clk_i;
  dsi_interlock #(.TICK_CYC(TK)) dsi_interlock_inst (.sys_clk_i, .rst_i, .alarm_i, .power_ok_i,
    .enable_i, .start_i, .dir_req_i, .key_up_i, .key_save_i, .key_start_i, .run_o, .bridge_fwd_o,
    .bridge_rev_o, .local_mode_o, .warning_code_o, .irq_o, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  dsi_keypad_model dsi_keypad_model_inst (.sys_clk_i, .chord_req_i(chord_req),
    .start_req_i(start_req), .key_up_o(key_up_i), .key_save_o(key_save_i), .key_start_o(key_start_i));
  ////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge sys_clk_i);
  endtask
  // A used-up wait bound is a failure.
  task automatic tmo(input int c);
    if (c >= 4000) begin
      num_errors++;
      stop_test();
    end
  endtask
  // Writes one word, releasing each channel once it is taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int c;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (c = 0; c < 4000; c++) begin
      @(posedge sys_clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    tmo(c);
    chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
    s_axi_bready <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  // Reads one word and compares data (on OKAY) and response.
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int c;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (c = 0; c < 4000; c++) begin
      @(posedge sys_clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    tmo(c);
    chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
    if (er == 2'h0) chk("rdata", s_axi_rdata, ed);
    s_axi_rready <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  // Waits for run (0), forward (1) or reverse (2) to reach v.
  task automatic wt(input int k, input logic v, output int c);
    for (c = 0; c < 4000; c++) begin
      if ((k == 0 ? run_o : k == 1 ? bridge_fwd_o : bridge_rev_o) === v) break;
      @(posedge sys_clk_i);
    end
    tmo(c);
  endtask
  task automatic chord;
    chord_req <= 1'b1;
    cyc(1);
    chord_req <= 1'b0;
    cyc(14);
  endtask
  ////////////////////////////////////////////////////////////
  // Reset values, clamps and unmapped offsets.
  task automatic t_regs;
    rd(8'h00, 32'h0, 2'h0);
    rd(8'h04, 32'h186A0, 2'h0);
    rd(8'h08, 32'h7D0, 2'h0);
    rd(8'h14, 32'h0, 2'h0);
    rd(8'h0C, 32'h1, 2'h0);
    rd(8'h18, 32'h0, 2'h2);
    wr(8'h18, 32'h1, 2'h2);
    wr(8'h08, 32'h1, 2'h0);
    rd(8'h08, 32'h12C, 2'h0);
    wr(8'h04, 32'hFFFFF, 2'h0);
    rd(8'h04, 32'h186A0, 2'h0);
  endtask
  // Self-restart after alarm and supply loss; enable gates run.
  task automatic t_self;
    wt(0, 1'b1, n);
    enable_i <= 1'b0;
    cyc(2);
    chk("run_o", run_o, 1'b0);
    enable_i <= 1'b1;
    start_i  <= 1'b0;
    cyc(2);
    chk("run_o", run_o, 1'b0);
    start_i  <= 1'b1;
    alarm_i  <= 1'b1;
    cyc(2);
    chk("run_o", run_o, 1'b0);
    alarm_i <= 1'b0;
    wt(0, 1'b1, n);
    power_ok_i <= 1'b0;
    cyc(2);
    power_ok_i <= 1'b1;
    wt(0, 1'b1, n);
  endtask
  // Interlock after alarm and after supply restore, with interrupt.
  task automatic t_lock;
    wr(8'h14, 32'h1, 2'h0);
    wr(8'h00, 32'h1, 2'h0);
    for (int i = 0; i < 2; i++) begin
      if (i == 0) alarm_i <= 1'b1;
      else power_ok_i <= 1'b0;
      cyc(2);
      alarm_i    <= 1'b0;
      power_ok_i <= 1'b1;
      cyc(6);
      chk("run_o", run_o, 1'b0);
      chk("warn", warning_code_o, 8'h04);
      chk("irq_o", irq_o, 1'b1);
      wr(8'h14, 32'h0, 2'h0);
      cyc(2);
      chk("irq_o", irq_o, 1'b0);
      wr(8'h10, 32'h1, 2'h0);
      wr(8'h14, 32'h1, 2'h0);
      cyc(2);
      chk("irq_o", irq_o, 1'b0);
      enable_i <= 1'b0;
      cyc(4);
      chk("warn", warning_code_o, 8'h00);
      enable_i <= 1'b1;
      wt(0, 1'b1, n);
    end
    wr(8'h00, 32'h0, 2'h0);
  endtask
  // Chord toggles local mode unless locked; local obeys the keypad only.
  task automatic t_chord;
    chord();
    chk("local", local_mode_o, 1'b1);
    chk("run_o", run_o, 1'b0);
    start_req <= 1'b1;
    wt(0, 1'b1, n);
    start_req <= 1'b0;
    wr(8'h00, 32'h2, 2'h0);
    chord();
    chk("local", local_mode_o, 1'b1);
    wr(8'h00, 32'h0, 2'h0);
    chord();
    chk("local", local_mode_o, 1'b0);
    wt(0, 1'b1, n);
  endtask
  // Reversal with an inductive load keeps both bridges off.
  task automatic t_rev;
    wr(8'h00, 32'h4, 2'h0);
    chk("run_o", run_o, 1'b0);
    wr(8'h04, 32'h1, 2'h0);
    wr(8'h08, 32'h12C, 2'h0);
    wt(0, 1'b1, n);
    wt(1, 1'b1, n);
    dir_req_i <= 1'b1;
    cyc(2);
    chk("fwd", bridge_fwd_o, 1'b0);
    chk("rev", bridge_rev_o, 1'b0);
    wt(2, 1'b1, n);
    chk("zero_long", n >= 300 * TK - 4, 1'b1);
    chk("zero_short", n <= 300 * TK + 8, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    cyc(3);
    rst_i <= 1'b0;
    cyc(1);
    t_regs();
    t_self();
    t_lock();
    t_chord();
    t_rev();
    stop_test();
  end
endmodule // tb_dsi_interlock
bind dsi_interlock dsi_interlock_properties dsi_interlock_properties_inst (.sys_clk_i, .rst_i,
  .alarm_i, .power_ok_i, .enable_i, .key_up_i, .key_save_i, .key_start_i, .run_o, .bridge_fwd_o,
  .bridge_rev_o, .local_mode_o, .warning_code_o, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);
